// file: shared/ppoc_pkg.sv
// ppoc_pkg: constants for the port pin override control block
// assumes one core clock, synchronous active-low reset
package ppoc_pkg;
   localparam int unsigned SYNC_STAGES = 3;                   // pad input synchroniser depth
   localparam int unsigned PIN_COUNT   = 8;                   // pins per port
   localparam logic [7:0]  DIR_RESET   = 8'h00;               // direction after reset
   localparam logic [7:0]  LATCH_RESET = 8'h00;               // output latch after reset
   localparam logic [7:0]  SAMP_RESET  = 8'h00;               // sampled input after reset
   localparam logic [2:0]  PULLUP_CODE = 3'h2;                // {dir, latch, global off} for pull-up
endpackage

// file: core/ppoc_port.sv
// ppoc_port: one general-purpose port of PINS bidirectional pins with
// alternate-function overrides, sleep clamp and pull-up control.
// assumes overrides come from on-chip peripherals on core_clk; pads are
// asynchronous; the pad wire is resolved outside from pad_out/pad_oe.
//
// What this block does
// - sleep signal clamps digital input to ground before sampling.
// - external interrupt enabled pins escape the sleep clamp.
// - releasing clamp on high pin without interrupt enabled produces the edge for its flag.
// - pull-ups stay off while reset is active.
// - pull-up follows override value, else on when dir/latch/off is 010.
// - driver enable follows override value when enabled, else direction bit.
// - driven level is override value when enabled, else latch bit.
// - toggle override enable inverts the output latch bit.
// - input buffer follows override value when enabled, else sleep state decides.
// - alternate functions get unsynchronised input sample.
// - analog path ties directly to the pad, no digital logic.
// - override signals come from owning peripherals, not port registers.
// - direction one is output, zero is input unless overridden.
// - latch enables pull-up on input pins, sets level on outputs.
// - writing one to input register toggles latch bit.
// - global pull-up off disables every pull-up without an override enabled.
//
// hazards and limits
// - the pad level crosses into core_clk through three flops; only the
//   clamped, unsynchronised sample goes to peripherals, which must
//   synchronise it themselves unless they use it as a clock
// - the analog path is a plain wire at the pad, outside this logic
// - pull-up and driver controls are combinational, so an override change
//   reaches the pad in the same cycle
// - status bits catch every change seen after synchronisation, including
//   the edge made when the sleep clamp lets go of a high pin
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module ppoc_port #(
   parameter int unsigned PINS = ppoc_pkg::PIN_COUNT       // pins in this port
)(
   input  wire logic            core_clk,                 // core clock, 200 MHz
   input  wire logic            rst_n,                    // synchronous reset, active low
   input  wire logic [2:0]      reg_addr,                 // 0 direction, 1 latch, 2 input, 3 control
   input  wire logic [PINS-1:0] reg_wdata,                // write data
   input  wire logic            reg_wr,                   // write strobe
   input  wire logic            reg_rd,                   // read strobe
   output logic [PINS-1:0]      reg_rdata,                // read data, cycle after strobe
   output logic                 irq,                      // level interrupt, unmasked status set
   input  wire logic            sleep_clamp,              // deep sleep clamp request
   input  wire logic [PINS-1:0] ext_int_en,               // external interrupt enabled per pin
   input  wire logic [PINS-1:0] pullup_override_en,       // pull-up override enable
   input  wire logic [PINS-1:0] pullup_override_val,      // pull-up override value
   input  wire logic [PINS-1:0] drive_override_en,        // direction override enable
   input  wire logic [PINS-1:0] drive_override_val,       // direction override value
   input  wire logic [PINS-1:0] outval_override_en,       // output value override enable
   input  wire logic [PINS-1:0] outval_override_val,      // output value override value
   input  wire logic [PINS-1:0] toggle_override_en,       // latch toggle, one-cycle pulse
   input  wire logic [PINS-1:0] inbuf_override_en,        // input buffer override enable
   input  wire logic [PINS-1:0] inbuf_override_val,       // input buffer override value
   output logic [PINS-1:0]      alt_func_pin_sample,      // clamped pad level, unsynchronised
   input  wire logic [PINS-1:0] pad_in,                   // pad level from the board
   output logic [PINS-1:0]      pad_out,                  // level driven onto the pad
   output logic [PINS-1:0]      pad_oe,                   // high while the pin is driven
   output logic [PINS-1:0]      pad_pullup                // pull-up enable
);

   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [2:0] ADDR_DIR   = 3'h0;
   localparam logic [2:0] ADDR_LATCH = 3'h1;
   localparam logic [2:0] ADDR_INPUT = 3'h2;
   localparam logic [2:0] ADDR_CTRL  = 3'h3;                // bit0 global pull-up off
   localparam logic [2:0] ADDR_STAT  = 3'h4;                // pin change status, w1c
   localparam logic [2:0] ADDR_MASK  = 3'h5;                // pin change mask

   logic [PINS-1:0]                  pin_direction_bit;
   logic [PINS-1:0]                  pin_output_latch_bit;
   logic [PINS-1:0]                  pin_sampled_input_bit;
   logic                             global_pullup_off;
   logic [PINS-1:0]                  chg_status;
   logic [PINS-1:0]                  chg_mask;
   logic [PINS-1:0]                  sync1;
   logic [PINS-1:0]                  sync2;
   logic [PINS-1:0]                  prev_level;
   logic [PINS-1:0]                  next_direction;
   logic [PINS-1:0]                  next_latch;
   logic                             next_pullup_off;
   logic [PINS-1:0]                  next_status;
   logic [PINS-1:0]                  next_mask;
   logic [PINS-1:0]                  next_rdata;
   logic [PINS-1:0]                  inbuf_en;
   logic [PINS-1:0]                  drv_en;
   logic [PINS-1:0]                  next_sampled;

   // ----------------------------------------
   // per-pin decode functions
   // ----------------------------------------
   // input buffer enable of one pin; the clamp acts only when nothing overrides it
   function automatic logic ppoc_inbuf_on
   (
      input logic ovr_en,                                   // override enable
      input logic ovr_val,                                  // override value
      input logic sleep,                                    // sleep clamp request
      input logic int_on                                    // external interrupt enabled
   );
      if (ovr_en)
         return ovr_val;
      return !sleep || int_on;
   endfunction

   // driver enable of one pin
   function automatic logic ppoc_drive_on
   (
      input logic ovr_en,                                   // override enable
      input logic ovr_val,                                  // override value
      input logic dir                                       // direction bit
   );
      return ovr_en ? ovr_val : dir;
   endfunction

   // driven level; zero while the driver is off so an idle pin shows no level
   function automatic logic ppoc_level
   (
      input logic drive,                                    // driver enabled
      input logic ovr_en,                                   // override enable
      input logic ovr_val,                                  // override value
      input logic latch                                     // output latch bit
   );
      return drive && (ovr_en ? ovr_val : latch);
   endfunction

   // pull-up of one pin outside reset
   function automatic logic ppoc_pullup_on
   (
      input logic ovr_en,                                   // override enable
      input logic ovr_val,                                  // override value
      input logic dir,                                      // direction bit
      input logic latch,                                    // output latch bit
      input logic off                                       // global pull-up off
   );
      if (ovr_en)
         return ovr_val;
      return {dir, latch, off} == ppoc_pkg::PULLUP_CODE;
   endfunction

   // ----------------------------------------
   // pad-facing combinational paths
   // ----------------------------------------
   // input buffer enable; interrupt pins escape the sleep clamp
   always_comb
   begin
      for (int i = 0; i < PINS; i++)
      begin
         inbuf_en[i] = ppoc_inbuf_on(inbuf_override_en[i], inbuf_override_val[i],
                                     sleep_clamp, ext_int_en[i]);
      end
   end

   // clamp to ground ahead of the trigger; clamped, unsynchronised level to peripherals
   assign alt_func_pin_sample = pad_in & inbuf_en;

   // driver enable and level
   always_comb
   begin
      for (int i = 0; i < PINS; i++)
      begin
         drv_en[i]  = ppoc_drive_on(drive_override_en[i], drive_override_val[i],
                                    pin_direction_bit[i]);
         pad_oe[i]  = drv_en[i];
         pad_out[i] = ppoc_level(drv_en[i], outval_override_en[i], outval_override_val[i],
                                 pin_output_latch_bit[i]);
      end
   end

   // pull-up control, forced off during reset
   always_comb
   begin
      for (int i = 0; i < PINS; i++)
      begin
         if (!rst_n)
            pad_pullup[i] = 1'b0;
         else
            pad_pullup[i] = ppoc_pullup_on(pullup_override_en[i], pullup_override_val[i],
                                           pin_direction_bit[i], pin_output_latch_bit[i],
                                           global_pullup_off);
      end
   end

   // ----------------------------------------
   // register next-state logic
   // ----------------------------------------
   // writes, toggles, change detection, read mux
   always_comb
   begin
      logic [PINS-1:0] changed;
      changed         = sync2 ^ prev_level;
      next_direction  = pin_direction_bit;
      next_latch      = pin_output_latch_bit ^ toggle_override_en;
      next_pullup_off = global_pullup_off;
      next_mask       = chg_mask;
      next_status     = chg_status;
      if (reg_wr)
      begin
         case (reg_addr)
            ADDR_DIR:   next_direction  = reg_wdata;
            ADDR_LATCH: next_latch      = reg_wdata ^ toggle_override_en;
            ADDR_INPUT: next_latch      = next_latch ^ reg_wdata;
            ADDR_CTRL:  next_pullup_off = reg_wdata[0];
            ADDR_STAT:  next_status     = chg_status & ~reg_wdata;
            ADDR_MASK:  next_mask       = reg_wdata;
            default:    next_mask       = chg_mask;
         endcase
      end
      next_status = next_status | changed;                    // set wins over clear
      next_rdata  = '0;
      if (reg_rd)
      begin
         case (reg_addr)
            ADDR_DIR:   next_rdata = pin_direction_bit;
            ADDR_LATCH: next_rdata = pin_output_latch_bit;
            ADDR_INPUT: next_rdata = pin_sampled_input_bit;
            ADDR_CTRL:  next_rdata = PINS'(global_pullup_off);
            ADDR_STAT:  next_rdata = chg_status;
            ADDR_MASK:  next_rdata = chg_mask;
            default:    next_rdata = '0;
         endcase
      end
   end

   // sampled input follows a pin once stages two and three agree
   always_comb
   begin
      next_sampled = pin_sampled_input_bit;
      for (int i = 0; i < PINS; i++)
      begin
         if (sync2[i] == prev_level[i])
            next_sampled[i] = sync2[i];
      end
   end

   // ----------------------------------------
   // registers and synchroniser
   // ----------------------------------------
   // the first stage may go metastable, so nothing but the second stage reads it
   // sync1 feeds only sync2; a change counts when sync2 and the third stage differ
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         pin_direction_bit     <= ppoc_pkg::DIR_RESET;
         pin_output_latch_bit  <= ppoc_pkg::LATCH_RESET;
         pin_sampled_input_bit <= ppoc_pkg::SAMP_RESET;
         global_pullup_off     <= 1'b0;
         chg_status            <= '0;
         chg_mask              <= '0;
         sync1                 <= '0;
         sync2                 <= '0;
         prev_level            <= '0;
         reg_rdata             <= '0;
      end
      else
      begin
         pin_direction_bit     <= next_direction;
         pin_output_latch_bit  <= next_latch;
         global_pullup_off     <= next_pullup_off;
         chg_status            <= next_status;
         chg_mask              <= next_mask;
         sync1                 <= alt_func_pin_sample;
         sync2                 <= sync1;
         prev_level            <= sync2;
         pin_sampled_input_bit <= next_sampled;
         reg_rdata             <= next_rdata;
      end
   end

   // ----------------------------------------
   // tie-offs and analog path
   // ----------------------------------------
   // pins with no alternate function get every override enable tied low at
   // the instance, leaving a plain register-controlled pin
   // the analog path is wired straight to the pad beside pad_in and never
   // passes any buffer or override logic of this block
   // overrides are inputs only, never written by the port registers

   // ----------------------------------------
   // interrupt
   // ----------------------------------------
   // level interrupt while any unmasked change flag is set
   assign irq = |(chg_status & chg_mask);

endmodule
`default_nettype wire

// file: testbench/ppoc_board.sv
// ppoc_board: board circuitry on the pads
// assumes the bench chooses which pins the board drives
`timescale 1ns/100ps
`default_nettype none
module ppoc_board #(parameter int unsigned PINS = 8)(
   input  wire logic            core_clk,                              // core clock
   input  wire logic [PINS-1:0] pad_out, pad_oe, pad_pullup, ext_en, ext_val, // pads and board drive
   output logic      [PINS-1:0] pad_in                                 // resolved pad level
);
   logic [PINS-1:0] drift = '0;
   // undriven pins wander every cycle
   always_ff @(posedge core_clk) drift <= ~drift;
   // port driver wins, then board, then pull-up, else floating
   always_comb pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) | (~pad_oe & ~ext_en & (pad_pullup | drift));
endmodule
`default_nettype wire

// file: testbench/ppoc_port_monitor.sv
// ppoc_port_monitor: pad, pull-up and input path checks
// assumes bind onto ppoc_port, one clock
`timescale 1ns/100ps
`default_nettype none
module ppoc_port_monitor #(parameter int unsigned PINS = 8)(
   input wire logic            core_clk, rst_n, reg_wr, sleep_clamp,  // clock, reset, strobe, clamp
   input wire logic [2:0]      reg_addr,                              // register select
   input wire logic [PINS-1:0] reg_wdata, ext_int_en, pullup_override_en, pullup_override_val, drive_override_en,
   input wire logic [PINS-1:0] drive_override_val, outval_override_en, outval_override_val, toggle_override_en,
   input wire logic [PINS-1:0] inbuf_override_en, inbuf_override_val, alt_func_pin_sample, pad_in, pad_out,
   input wire logic [PINS-1:0] pad_oe, pad_pullup                     // pad side
);
   // expected input enable, latch flips, cycles free of other latch causes
   wire logic [PINS-1:0] ie = (inbuf_override_en & inbuf_override_val)
                            | (~inbuf_override_en & ({PINS{~sleep_clamp}} | ext_int_en));
   wire logic [PINS-1:0] tg = toggle_override_en ^ ((reg_wr && reg_addr == 3'h2) ? reg_wdata : '0);
   wire logic qt = !(reg_wr && reg_addr < 3'h2) && drive_override_en == '0 && outval_override_en == '0;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_quiet; qt; endsequence
   property p_pu_reset; disable iff (1'b0) !rst_n |-> pad_pullup == '0; endproperty
   property p_pu_ovr; ((pad_pullup ^ pullup_override_val) & pullup_override_en) == '0; endproperty
   property p_pu_out; (pad_pullup & pad_oe & ~pullup_override_en & ~drive_override_en) == '0; endproperty
   property p_drive; ((pad_oe ^ drive_override_val) & drive_override_en) == '0; endproperty
   property p_level; ((pad_out ^ outval_override_val) & outval_override_en & pad_oe) == '0; endproperty
   property p_hiz; (pad_out & ~pad_oe) == '0; endproperty
   property p_clamp; sleep_clamp |-> (alt_func_pin_sample & ~inbuf_override_en & ~ext_int_en) == '0; endproperty
   property p_inbuf; alt_func_pin_sample == (pad_in & ie); endproperty
   property p_toggle; s_quiet ##1 s_quiet |-> ((pad_out ^ $past(pad_out)) & pad_oe) == ($past(tg) & pad_oe); endproperty
   a_pu_reset: assert property (p_pu_reset) else $error("pull-up on in reset");
   a_pu_ovr: assert property (p_pu_ovr) else $error("pull-up override ignored");
   a_pu_out: assert property (p_pu_out) else $error("pull-up on output pin");
   a_drive: assert property (p_drive) else $error("driver override ignored");
   a_level: assert property (p_level) else $error("level override ignored");
   a_hiz: assert property (p_hiz) else $error("level on undriven pin");
   a_clamp: assert property (p_clamp) else $error("clamp leaked");
   a_inbuf: assert property (p_inbuf) else $error("input path wrong");
   a_toggle: assert property (p_toggle) else $error("latch toggle wrong");
endmodule
bind ppoc_port ppoc_port_monitor #(.PINS(PINS)) ppoc_port_monitor_i (.*);
`default_nettype wire

// file: testbench/tb_ppoc_port.sv
// tb_ppoc_port: register, override, sleep and interrupt tests
// assumes ppoc_port, the board model and the bound monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin fails++; $display("MISMATCH %0t %s", $time, m); end end
module tb_ppoc_port;
   localparam int unsigned N = ppoc_pkg::PIN_COUNT;
   logic         core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, sleep_clamp = 1'b0, gpo = 1'b0;
   logic [2:0]   reg_addr = 3'h0;
   logic [N-1:0] wdata = '0, int_en = '0, pu_en = '0, pu_val = '0, dr_en = '0, dr_val = '0, ov_en = '0, oe;
   logic [N-1:0] ov_val = '0, tog = '0, ib_en = '0, ib_val = '0, ext_en = '0, ext_val = '0, dir = '0, lat = '0;
   wire logic [N-1:0] rdata, alt, pin, pout, poe, ppu;
   wire logic    irq;
   int           fails = 0, n_checks = 0;
   logic [31:0]  seed = 32'h0000_4fe4;
   ppoc_port ppoc_port_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(rdata), .irq(irq), .sleep_clamp(sleep_clamp), .ext_int_en(int_en),
      .pullup_override_en(pu_en), .pullup_override_val(pu_val), .drive_override_en(dr_en), .drive_override_val(dr_val),
      .outval_override_en(ov_en), .outval_override_val(ov_val), .toggle_override_en(tog), .inbuf_override_en(ib_en),
      .inbuf_override_val(ib_val), .alt_func_pin_sample(alt), .pad_in(pin), .pad_out(pout), .pad_oe(poe), .pad_pullup(ppu));
   ppoc_board ppoc_board_i (.core_clk(core_clk), .pad_out(pout), .pad_oe(poe), .pad_pullup(ppu), .ext_en(ext_en),
      .ext_val(ext_val), .pad_in(pin));
   function automatic logic [N-1:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[N-1:0];
   endfunction
   // bus write and read, one idle cycle after each strobe
   task automatic wr(input logic [2:0] a, input logic [N-1:0] d);
      reg_addr <= a; wdata <= d; reg_wr <= 1'b1;
      @(posedge core_clk) reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [2:0] a, input logic [N-1:0] e);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge core_clk) reg_rd <= 1'b0;
      @(negedge core_clk) `CHK(rdata, e, "read data")
      @(posedge core_clk);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial forever #2.5 core_clk = ~core_clk;
   initial
   begin
      #100000;
      fails++;
      print_verdict();
   end
   initial
   begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      dir = rnd();
      lat = rnd();
      wr(3'h0, dir); wr(3'h1, lat); rd(3'h0, dir); rd(3'h6, '0);
      wr(3'h2, 8'h5a); lat ^= 8'h5a; rd(3'h1, lat);
      $display("registers done");
      for (int k = 0; k < 2; k++)
      begin
         wr(3'h3, N'(k)); gpo = k[0]; rd(3'h3, N'(k));
         repeat (200)
         begin
            @(posedge core_clk) lat ^= tog;
            {pu_en, pu_val, dr_val, ov_val, tog, ib_en, ib_val} <= {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
            {int_en, ext_en, ext_val, sleep_clamp} <= {rnd(), rnd(), rnd(), seed[9]};
            {dr_en, ov_en} <= seed[5] ? {rnd(), rnd()} : '0;
            @(negedge core_clk) oe = (dr_en & dr_val) | (~dr_en & dir);
            `CHK(poe, oe, "driver enable")
            `CHK(pout, oe & ((ov_en & ov_val) | (~ov_en & lat)), "driven level")
            `CHK(ppu, (pu_en & pu_val) | (~pu_en & ~dir & lat & {N{~gpo}}), "pull-up")
            `CHK(alt, pin & ((ib_en & ib_val) | (~ib_en & ({N{~sleep_clamp}} | int_en))), "input path")
         end
         @(posedge core_clk) lat ^= tog;
         {tog, dr_en, ov_en, pu_en, ib_en, sleep_clamp} <= '0;
      end
      $display("overrides done");
      {ext_en, ext_val, int_en} <= {{2*N{1'b1}}, 8'h0f};
      wr(3'h0, '0); repeat (8) @(posedge core_clk);
      wr(3'h5, '0); sleep_clamp <= 1'b1; repeat (8) @(posedge core_clk);
      wr(3'h4, '1); rd(3'h2, 8'h0f); @(negedge core_clk) `CHK(alt, 8'h0f, "clamp")
      @(posedge core_clk) sleep_clamp <= 1'b0;
      repeat (8) @(posedge core_clk);
      `CHK(irq, 1'b0, "masked irq")
      rd(3'h2, 8'hff);
      rd(3'h4, 8'hf0); wr(3'h5, '1); `CHK(irq, 1'b1, "irq raised")
      rd(3'h5, 8'hff);
      wr(3'h4, 8'hf0); `CHK(irq, 1'b0, "irq cleared")
      $display("sleep done");
      print_verdict();
   end
endmodule
`default_nettype wire
